/* rtl/e1_line_pkg.sv */
// Overview of operation
// - Signal loss: recovered clock follows master reference
// - Normally recovered clock tracks received line timing
// - Transmit rails captured on transmit clock falling
// - Transmitter stays powered down without transmit clock
// - Strap high selects host mode, serial control
// - Strap low disables serial port, pin control
// - Positive or negative line pulse sets matching rail
// - Receive rails are NRZ, held one bit
// - Host mode: edge select picks valid clock edge
// - Pin mode: rails valid at recovered rising edge
// - Loss after 175 zero bits, clears on density
package e1_line_pkg;

   // Clock of this block and nominal line bit time
   localparam int CLK_PERIOD_NS = 100;
   localparam int BIT_PERIOD_NS = 488;
   // Bit time in block clocks, rounded to nearest since edges re-align it
   localparam int BIT_CYCLES = (BIT_PERIOD_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
   localparam int HALF_CYCLES = BIT_CYCLES / 2;
   // Phase loaded into the bit counter when a mark edge is seen
   localparam int ALIGN_PHASE = 1;
   localparam int CNT_W = 8;

   // Signal loss detection figures
   localparam int LOS_SET_ZEROS = 175;
   localparam int LOS_CLR_WINDOW = 32;
   localparam int LOS_CLR_MARKS = 4;
   localparam int LOS_CLR_MAX_ZEROS = 15;
   localparam int LOS_CNT_W = 8;

   // Transmit clock presence timeout, as a time and as clocks
   localparam int TX_CLK_TIMEOUT_NS = 6400;
   localparam int TX_CLK_TIMEOUT_CYCLES = TX_CLK_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int TXTO_W = 8;

   // Mode strap levels
   localparam logic MODE_HOST = 1'h1;
   localparam logic MODE_PINS = 1'h0;
   // Edge select levels: data valid on rising or falling recovered edge
   localparam logic EDGE_VALID_RISE = 1'h1;
   localparam logic EDGE_VALID_FALL = 1'h0;

endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser with one extra stage for edge detection
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] q_prev
);
   logic [W-1:0] meta_r; // First stage, read only by the second
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;
   logic [W-1:0] prev_r;
   logic [W-1:0] prev_nxt;

   // Shift chain; clock enable freezes every stage
   always_comb begin
      meta_nxt = meta_r;
      q_nxt = q_r;
      prev_nxt = prev_r;
      if (ce) begin
         meta_nxt = d;
         q_nxt = meta_r;
         prev_nxt = q_r;
      end
   end

   // Synchronous reset to constants only
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_r <= '0;
         q_r <= '0;
         prev_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
         prev_r <= prev_nxt;
      end
   end

   assign q = q_r;
   assign q_prev = prev_r;
endmodule
`default_nettype wire

/* rtl/e1_dual_rail_line_interface.sv */
`timescale 1ns/1ns
`default_nettype none
// Digital side of an E1 short-haul line interface
module e1_dual_rail_line_interface
   import e1_line_pkg::*;
#(
   parameter int BIT_CLKS = BIT_CYCLES,
   parameter int TX_TIMEOUT = TX_CLK_TIMEOUT_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic MCLK_REF,
   input wire logic TX_SAMPLE_CLOCK,
   input wire logic TX_MARK_POSITIVE,
   input wire logic TX_MARK_NEGATIVE,
   input wire logic MODE_STRAP,
   input wire logic OUTPUT_EDGE_SELECT,
   input wire logic RX_LINE_TIP,
   input wire logic RX_LINE_RING,
   output logic RX_MARK_POSITIVE,
   output logic RX_MARK_NEGATIVE,
   output logic RX_RECOVERED_CLOCK,
   output logic SIGNAL_LOSS_FLAG,
   output logic TX_PULSE_POSITIVE,
   output logic TX_PULSE_NEGATIVE,
   output logic TX_POWER_UP,
   output logic SERIAL_PORT_ENABLE
);

   // Every outside input but CLK, RST and CE passes the synchroniser; edges come from stage two and three
   logic [7:0] s_q;
   logic [7:0] s_p;
   pin_sync #(.W(8)) u_sync (
      .clk(CLK),
      .rst(RST),
      .ce(CE),
      .d({MCLK_REF, TX_SAMPLE_CLOCK, TX_MARK_POSITIVE, TX_MARK_NEGATIVE,
          MODE_STRAP, OUTPUT_EDGE_SELECT, RX_LINE_TIP, RX_LINE_RING}),
      .q(s_q),
      .q_prev(s_p)
   );

   logic mclk_s, tx_sample_clock_s, tx_mark_positive_s, tx_mark_negative_s, mode_s, edge_s, tip_s, ring_s;
   assign {mclk_s, tx_sample_clock_s, tx_mark_positive_s, tx_mark_negative_s, mode_s, edge_s, tip_s, ring_s} = s_q;

   // Rising and falling edges of synchronised levels
   function automatic logic rose(input logic now, input logic was);
      return now & ~was;
   endfunction

   logic mclk_rise, mclk_fall, tx_sample_clock_fall, pos_mark, neg_mark, any_mark;
   assign mclk_rise = rose(mclk_s, s_p[7]);
   assign mclk_fall = rose(s_p[7], mclk_s);
   assign tx_sample_clock_fall = rose(s_p[6], tx_sample_clock_s);
   assign pos_mark = rose(tip_s, s_p[1]);
   assign neg_mark = rose(ring_s, s_p[0]);
   assign any_mark = pos_mark | neg_mark;

   // Host mode when strap is high; serial port dead otherwise
   logic host_mode;
   assign host_mode = (mode_s == MODE_HOST);

   // ---------------- Transmit path ----------------
   logic tx_pos_r, tx_pos_nxt; // Captured positive rail
   logic tx_neg_r, tx_neg_nxt; // Captured negative rail
   logic tx_up_r, tx_up_nxt; // Transmitter powered
   logic [TXTO_W-1:0] tx_to_r, tx_to_nxt; // Clocks since last transmit edge

   // Rails taken on the transmit clock falling edge. The rails share the
   // clock's synchroniser delay, so the framer's setup/hold maps over intact.
   always_comb begin
      tx_pos_nxt = tx_pos_r;
      tx_neg_nxt = tx_neg_r;
      tx_up_nxt = tx_up_r;
      tx_to_nxt = tx_to_r;
      if (CE) begin
         if (tx_sample_clock_fall) begin
            tx_to_nxt = '0;
            tx_up_nxt = 1'h1;
            tx_pos_nxt = tx_mark_positive_s;
            tx_neg_nxt = tx_mark_negative_s;
         end else if (tx_to_r >= TXTO_W'(TX_TIMEOUT - 1)) begin
            // Transmit clock gone: power down and stop driving marks
            tx_up_nxt = 1'h0;
            tx_pos_nxt = 1'h0;
            tx_neg_nxt = 1'h0;
         end else begin
            tx_to_nxt = tx_to_r + TXTO_W'(1);
         end
      end
   end

   // Transmit registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         tx_pos_r <= 1'h0;
         tx_neg_r <= 1'h0;
         tx_up_r <= 1'h0;
         tx_to_r <= '0;
      end else begin
         tx_pos_r <= tx_pos_nxt;
         tx_neg_r <= tx_neg_nxt;
         tx_up_r <= tx_up_nxt;
         tx_to_r <= tx_to_nxt;
      end
   end

   // Marks reach the driver only while powered; both at once is the
   // framer's fault and is passed through unchanged.
   assign TX_PULSE_POSITIVE = tx_pos_r & tx_up_r;
   assign TX_PULSE_NEGATIVE = tx_neg_r & tx_up_r;
   assign TX_POWER_UP = tx_up_r;

   // ---------------- Receive clock recovery ----------------
   logic [CNT_W-1:0] cnt_r, cnt_nxt; // Phase inside the bit
   logic loss_r, loss_nxt; // Signal loss flag
   logic line_rise, line_fall, rise_ev, fall_ev, late_mark;

   // Mark past mid-bit starts a new bit at once
   assign late_mark = any_mark && (cnt_r >= CNT_W'(HALF_CYCLES));
   assign line_rise = (cnt_r == CNT_W'(BIT_CLKS - 1)) || late_mark;
   assign line_fall = (cnt_r == CNT_W'(HALF_CYCLES - 1)) && !any_mark;
   // Clock source switches to the master reference on signal loss
   assign rise_ev = loss_r ? mclk_rise : line_rise;
   assign fall_ev = loss_r ? mclk_fall : line_fall;

   // Bit counter: free runs at the nominal rate, re-phased by each mark
   always_comb begin
      cnt_nxt = cnt_r;
      if (CE) begin
         if (any_mark) begin
            cnt_nxt = CNT_W'(ALIGN_PHASE);
         end else if (cnt_r == CNT_W'(BIT_CLKS - 1)) begin
            cnt_nxt = '0;
         end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
         end
      end
   end

   // ---------------- Receive data and clock output ----------------
   logic acc_pos_r, acc_pos_nxt; // Marks seen in the current bit
   logic acc_neg_r, acc_neg_nxt;
   logic stg_pos_r, stg_pos_nxt; // Last finished bit, waiting for output edge
   logic stg_neg_r, stg_neg_nxt;
   logic rx_mark_positive_r, rx_mark_positive_nxt; // Output rails
   logic rx_mark_negative_r, rx_mark_negative_nxt;
   logic rclk_r, rclk_nxt; // Recovered clock output
   logic valid_on_rise;

   // Pin mode always rising; host mode follows the edge select input
   assign valid_on_rise = host_mode ? (edge_s == EDGE_VALID_RISE) : 1'h1;

   // Data rails change on the edge opposite the one they are valid on,
   // giving half a bit of setup and hold to the framer
   always_comb begin
      acc_pos_nxt = acc_pos_r;
      acc_neg_nxt = acc_neg_r;
      stg_pos_nxt = stg_pos_r;
      stg_neg_nxt = stg_neg_r;
      rx_mark_positive_nxt = rx_mark_positive_r;
      rx_mark_negative_nxt = rx_mark_negative_r;
      rclk_nxt = rclk_r;
      if (CE) begin
         if (rise_ev) begin
            // Close the bit; a coincident mark opens the next one
            rclk_nxt = 1'h1;
            stg_pos_nxt = acc_pos_r;
            stg_neg_nxt = acc_neg_r;
            acc_pos_nxt = pos_mark;
            acc_neg_nxt = neg_mark;
            if (!valid_on_rise) begin
               rx_mark_positive_nxt = acc_pos_r;
               rx_mark_negative_nxt = acc_neg_r;
            end
         end else begin
            acc_pos_nxt = acc_pos_r | pos_mark;
            acc_neg_nxt = acc_neg_r | neg_mark;
            if (fall_ev) begin
               rclk_nxt = 1'h0;
               if (valid_on_rise) begin
                  rx_mark_positive_nxt = stg_pos_r;
                  rx_mark_negative_nxt = stg_neg_r;
               end
            end
         end
      end
   end

   // ---------------- Signal loss ----------------
   logic [LOS_CNT_W-1:0] zrun_r, zrun_nxt; // Consecutive zero bits
   logic [LOS_CNT_W-1:0] clean_r, clean_nxt; // Bits since a long zero run
   logic [LOS_CLR_WINDOW-1:0] hist_r, hist_nxt; // Marks of the last window

   // Ones in the history window
   function automatic logic [LOS_CNT_W-1:0] ones(input logic [LOS_CLR_WINDOW-1:0] v);
      logic [LOS_CNT_W-1:0] n;
      n = '0;
      for (int i = 0; i < LOS_CLR_WINDOW; i++) begin
         n = n + LOS_CNT_W'(v[i]);
      end
      return n;
   endfunction

   // Counted per bit on the line's own timing; during loss the master
   // reference paces bits so a dead line still ages the counters
   always_comb begin
      logic mark_bit;
      mark_bit = acc_pos_r | acc_neg_r;
      zrun_nxt = zrun_r;
      clean_nxt = clean_r;
      hist_nxt = hist_r;
      loss_nxt = loss_r;
      if (CE && rise_ev) begin
         hist_nxt = {hist_r[LOS_CLR_WINDOW-2:0], mark_bit};
         if (mark_bit) begin
            zrun_nxt = '0;
         end else if (zrun_r != '1) begin
            zrun_nxt = zrun_r + LOS_CNT_W'(1);
         end
         // A run over the limit restarts the clean window
         if (!mark_bit && zrun_r >= LOS_CNT_W'(LOS_CLR_MAX_ZEROS)) begin
            clean_nxt = '0;
         end else if (clean_r != '1) begin
            clean_nxt = clean_r + LOS_CNT_W'(1);
         end
         if (!loss_r && !mark_bit && zrun_r >= LOS_CNT_W'(LOS_SET_ZEROS)) begin
            loss_nxt = 1'h1;
         end else if (loss_r && clean_nxt >= LOS_CNT_W'(LOS_CLR_WINDOW)
                      && ones(hist_nxt) >= LOS_CNT_W'(LOS_CLR_MARKS)) begin
            loss_nxt = 1'h0;
         end
      end
   end

   // Receive and loss registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         cnt_r <= '0;
         acc_pos_r <= 1'h0;
         acc_neg_r <= 1'h0;
         stg_pos_r <= 1'h0;
         stg_neg_r <= 1'h0;
         rx_mark_positive_r <= 1'h0;
         rx_mark_negative_r <= 1'h0;
         rclk_r <= 1'h0;
         zrun_r <= '0;
         clean_r <= '0;
         hist_r <= '0;
         loss_r <= 1'h0;
      end else begin
         cnt_r <= cnt_nxt;
         acc_pos_r <= acc_pos_nxt;
         acc_neg_r <= acc_neg_nxt;
         stg_pos_r <= stg_pos_nxt;
         stg_neg_r <= stg_neg_nxt;
         rx_mark_positive_r <= rx_mark_positive_nxt;
         rx_mark_negative_r <= rx_mark_negative_nxt;
         rclk_r <= rclk_nxt;
         zrun_r <= zrun_nxt;
         clean_r <= clean_nxt;
         hist_r <= hist_nxt;
         loss_r <= loss_nxt;
      end
   end

   assign RX_MARK_POSITIVE = rx_mark_positive_r;
   assign RX_MARK_NEGATIVE = rx_mark_negative_r;
   assign RX_RECOVERED_CLOCK = rclk_r;
   // Loss is reported on its own pin in both modes
   assign SIGNAL_LOSS_FLAG = loss_r;
   assign SERIAL_PORT_ENABLE = host_mode;

endmodule
`default_nettype wire

/* tb/e1_line_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
// Timing relations watched at the line interface ports
module e1_line_asserts #(
   parameter int TX_TIMEOUT = 64
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic MCLK_REF,
   input wire logic TX_SAMPLE_CLOCK,
   input wire logic TX_MARK_POSITIVE,
   input wire logic MODE_STRAP,
   input wire logic OUTPUT_EDGE_SELECT,
   input wire logic RX_LINE_TIP,
   input wire logic RX_MARK_POSITIVE,
   input wire logic RX_RECOVERED_CLOCK,
   input wire logic SIGNAL_LOSS_FLAG,
   input wire logic TX_PULSE_POSITIVE,
   input wire logic TX_PULSE_NEGATIVE,
   input wire logic TX_POWER_UP,
   input wire logic SERIAL_PORT_ENABLE
);
   // Cycles since reset, since the transmit clock moved, since a mode pin moved
   logic [7:0] age_r, idle_r, calm_r, age_nxt, idle_nxt, calm_nxt;
   // Pin levels of the previous cycle
   logic tck_r, mod_r, sel_r;
   // Counters saturate, so a long stop never wraps back to zero
   always_comb begin
      age_nxt = age_r + {7'h00, age_r != 8'hFF};
      idle_nxt = (tck_r != TX_SAMPLE_CLOCK) ? 8'h00 : idle_r + {7'h00, idle_r != 8'hFF};
      calm_nxt = (mod_r != MODE_STRAP || sel_r != OUTPUT_EDGE_SELECT) ? 8'h00 : calm_r + {7'h00, calm_r != 8'hFF};
   end
   // Registers only
   always_ff @(posedge CLK) begin
      if (RST) begin
         age_r <= 8'h00;
         idle_r <= 8'h00;
         calm_r <= 8'h00;
      end else begin
         age_r <= age_nxt;
         idle_r <= idle_nxt;
         calm_r <= calm_nxt;
      end
      tck_r <= TX_SAMPLE_CLOCK;
      mod_r <= MODE_STRAP;
      sel_r <= OUTPUT_EDGE_SELECT;
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // Falling transmit clock, once the synchronisers are past reset
   sequence tx_fall_s;
      $fell(TX_SAMPLE_CLOCK) && age_r > 8'h04;
   endsequence
   // Loss flagged long enough for the clock switch to settle
   sequence loss_held_s;
      SIGNAL_LOSS_FLAG [*4];
   endsequence
   serial_port_a: assert property (
      age_r > 8'h03 |-> SERIAL_PORT_ENABLE == $past(MODE_STRAP, 2))
      else $error("port enable does not follow strap");
   power_off_a: assert property (
      !TX_POWER_UP |-> !TX_PULSE_POSITIVE && !TX_PULSE_NEGATIVE)
      else $error("pulse while powered down");
   power_idle_a: assert property (
      idle_r > TX_TIMEOUT + 8 |-> !TX_POWER_UP)
      else $error("power kept without transmit clock");
   tx_capture_a: assert property (
      tx_fall_s |-> ##4 TX_POWER_UP && TX_PULSE_POSITIVE == $past(TX_MARK_POSITIVE, 4))
      else $error("rail not captured at falling edge");
   loss_clock_a: assert property (
      loss_held_s |-> RX_RECOVERED_CLOCK == $past(MCLK_REF, 3))
      else $error("clock not from reference in loss");
   clock_track_a: assert property (
      $rose(RX_LINE_TIP) && !SIGNAL_LOSS_FLAG && age_r > 8'h04 |-> ##[2:10] $rose(RX_RECOVERED_CLOCK))
      else $error("recovered clock ignores line");
   rails_rise_a: assert property (
      $changed(RX_MARK_POSITIVE) && calm_r > 8'h08 && (!SERIAL_PORT_ENABLE || OUTPUT_EDGE_SELECT)
      |-> !RX_RECOVERED_CLOCK)
      else $error("rail moved near rising edge");
   rails_fall_a: assert property (
      $changed(RX_MARK_POSITIVE) && calm_r > 8'h08 && SERIAL_PORT_ENABLE && !OUTPUT_EDGE_SELECT
      |-> RX_RECOVERED_CLOCK)
      else $error("rail moved near falling edge");
   nrz_hold_a: assert property (
      $changed(RX_MARK_POSITIVE) && calm_r > 8'h08 |=> $stable(RX_MARK_POSITIVE) [*2])
      else $error("rail not held for a bit");
endmodule
bind e1_dual_rail_line_interface e1_line_asserts #(.TX_TIMEOUT(TX_TIMEOUT)) chk (
   .CLK, .RST, .MCLK_REF, .TX_SAMPLE_CLOCK, .TX_MARK_POSITIVE, .MODE_STRAP,
   .OUTPUT_EDGE_SELECT, .RX_LINE_TIP, .RX_MARK_POSITIVE, .RX_RECOVERED_CLOCK,
   .SIGNAL_LOSS_FLAG, .TX_PULSE_POSITIVE, .TX_PULSE_NEGATIVE, .TX_POWER_UP,
   .SERIAL_PORT_ENABLE
);
`default_nettype wire

/* tb/e1_framer_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Framer side: master reference, transmit clock and rails
module e1_framer_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   output logic mclk,
   output logic tx_sample_clock,
   output logic tx_mark_positive,
   output logic tx_mark_negative
);
   logic [2:0] ph = 3'h0; // Phase in the 800 ns transmit bit
   logic [2:0] mph = 3'h0; // Phase of the reference
   logic [1:0] sym = 2'h0; // Mark, space, mark, space
   initial begin
      mclk = 1'h0;
      tx_sample_clock = 1'h0;
      tx_mark_positive = 1'h0;
      tx_mark_negative = 1'h0;
   end
   // Reference near 2 MHz, the best a 10 MHz grid allows; runs free
   always @(posedge clk) begin
      mph <= (mph == 3'h4) ? 3'h0 : mph + 3'h1;
      mclk <= (mph < 3'h2);
   end
   // Rails move with the rising clock, four clocks clear of the falling one
   always @(posedge clk) begin
      if (rst) begin
         ph <= 3'h0;
         sym <= 2'h0;
      end else if (!run) begin
         tx_mark_positive <= ~tx_mark_positive; // Clock stands still; idle rail shows no stale value
         tx_mark_negative <= 1'h0;
      end else begin
         ph <= ph + 3'h1;
         tx_sample_clock <= ~ph[2];
         if (ph == 3'h0) begin
            sym <= sym + 2'h1;
            tx_mark_positive <= (sym == 2'h0);
            tx_mark_negative <= (sym == 2'h2);
         end
      end
   end
endmodule
`default_nettype wire

/* tb/e1_dual_rail_line_interface_test.sv */
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the E1 line interface
module e1_dual_rail_line_interface_test;
   import e1_line_pkg::*;
   logic clk = 1'h0, rst = 1'h1, strap = 1'h0, sel = 1'h0, tip = 1'h0, ring = 1'h0, run = 1'h0;
   wire logic mclk, tck, tp, tn, rxp, rxn, rck, signal_loss_flag, txp, txn, pwr, spe;
   int n_fail = 0, cmp_count = 0, cyc = 0, np = 0, nn = 0, nc = 0, nt = 0, nq = 0;
   always #50 clk = ~clk;
   // Edge counters on the outputs
   always @(posedge rxp) np = np + 1;
   always @(posedge rxn) nn = nn + 1;
   always @(posedge rck) nc = nc + 1;
   always @(posedge txp) nt = nt + 1;
   always @(posedge txn) nq = nq + 1;
   // Short timeout keeps the transmit stop test brief
   e1_dual_rail_line_interface #(.TX_TIMEOUT(16)) DUT (
      .CLK(clk), .RST(rst), .CE(1'h1), .MCLK_REF(mclk), .TX_SAMPLE_CLOCK(tck),
      .TX_MARK_POSITIVE(tp), .TX_MARK_NEGATIVE(tn), .MODE_STRAP(strap),
      .OUTPUT_EDGE_SELECT(sel), .RX_LINE_TIP(tip), .RX_LINE_RING(ring),
      .RX_MARK_POSITIVE(rxp), .RX_MARK_NEGATIVE(rxn), .RX_RECOVERED_CLOCK(rck),
      .SIGNAL_LOSS_FLAG(signal_loss_flag), .TX_PULSE_POSITIVE(txp), .TX_PULSE_NEGATIVE(txn),
      .TX_POWER_UP(pwr), .SERIAL_PORT_ENABLE(spe));
   e1_framer_model fr (.clk(clk), .rst(rst), .run(run), .mclk(mclk), .tx_sample_clock(tck), .tx_mark_positive(tp), .tx_mark_negative(tn));
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One line bit of five clocks; a mark is a pulse two clocks wide
   task automatic send(input logic p, input logic n);
      tip <= p;
      ring <= n;
      tick(2);
      tip <= 1'h0;
      ring <= 1'h0;
      tick(3);
   endtask
   // Outputs idle after reset, then the strap moves the serial port
   task automatic t_mode();
      check("reset", {signal_loss_flag, pwr, spe, txp, txn}, 5'h00);
      strap <= MODE_HOST;
      tick(4);
      check("port_en", spe, MODE_HOST);
      strap <= MODE_PINS;
      tick(4);
      check("port_en", spe, MODE_PINS);
   endtask
   // Transmit clock starts, pulses flow, then the clock stops
   task automatic t_tx();
      run <= 1'h1;
      for (int i = 0; i < 40 && pwr !== 1'h1; i++) tick(1);
      check("power", pwr, 1'h1);
      tick(48);
      check("pulsed", nt > 0, 1'h1);
      check("pulsed_neg", nq > 0, 1'h1);
      run <= 1'h0;
      tick(60);
      check("power", pwr, 1'h0);
      check("pulses", {txp, txn}, 2'h0);
   endtask
   // Twenty positive then twenty negative marks, spaces between
   task automatic t_rx(input logic m, input logic e);
      strap <= m;
      sel <= e;
      tick(10);
      np = 0;
      nn = 0;
      nc = 0;
      for (int i = 0; i < 40; i++) begin
         send(i < 20, i >= 20);
         send(1'h0, 1'h0);
      end
      tick(20);
      check("pos_marks", np, 16'd20);
      check("neg_marks", nn, 16'd20);
      check("rclk", nc >= 80 && nc <= 88, 1'h1);
   endtask
   // Long zero run raises loss; a short burst is not yet enough to clear it
   task automatic t_loss();
      tick(160 * 5);
      check("loss", signal_loss_flag, 1'h0);
      tick(20 * 5);
      check("loss", signal_loss_flag, 1'h1);
      repeat (10) send(1'h1, 1'h0);
      check("loss", signal_loss_flag, 1'h1);
      repeat (30) send(1'h1, 1'h0);
      check("loss", signal_loss_flag, 1'h0);
   endtask
   // Hang guard: the sequence needs about 2500 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         end_of_test();
      end
   end
   initial begin
      tick(12);
      rst <= 1'h0;
      tick(3);
      t_mode();
      t_tx();
      // Pin mode must ignore the edge select, so give it the falling choice
      t_rx(MODE_PINS, EDGE_VALID_FALL);
      t_rx(MODE_HOST, EDGE_VALID_FALL);
      t_rx(MODE_HOST, EDGE_VALID_RISE);
      t_loss();
      end_of_test();
   end
endmodule
`default_nettype wire
